// ==== include/usd_pkg.sv ====
package usd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Device register offsets.
	localparam logic [7:0] OFS_FRAME = 8'h00;
	localparam logic [7:0] OFS_GLOBAL = 8'h04;
	localparam logic [7:0] OFS_FADDR = 8'h08;
	localparam logic [7:0] OFS_IER = 8'h10;
	localparam logic [7:0] OFS_IDR = 8'h14;
	localparam logic [7:0] OFS_IMR = 8'h18;
	localparam logic [7:0] OFS_ISR = 8'h1C;
	localparam logic [7:0] OFS_ICR = 8'h20;
	localparam logic [7:0] OFS_EPRST = 8'h28;
	localparam logic [7:0] OFS_CSR = 8'h30;
	localparam logic [7:0] OFS_FDR = 8'h50;
	localparam logic [7:0] OFS_TXVC = 8'h74;
	localparam int NUM_EP = 4;

	// Interrupt bit positions and reset values.
	localparam int IRQ_SUSPEND = 8;
	localparam int IRQ_SOF = 11;
	localparam int IRQ_BUSRST = 12;
	localparam int IRQ_WAKEUP = 13;
	localparam logic [31:0] IMR_RESET = 32'h0000_1200;
	localparam logic [31:0] FADDR_RESET = 32'h0000_0100;
	localparam logic [31:0] IRQ_MASKABLE = 32'h0000_2B0F;
	localparam logic [31:0] IER_DEFAULT = 32'h0000_2101;

	// Endpoint control field positions, and global, address and transceiver bits.
	localparam int CSR_IN_PACKET_ACKNOWLEDGED = 0;
	localparam int CSR_SENT = 3;
	localparam int CSR_FORCE = 5;
	localparam int CSR_TYPE_LSB = 8;
	localparam int CSR_EPEN = 15;
	localparam int GLB_ADDR = 0;
	localparam int GLB_CONF = 1;
	localparam int FADDR_FEN = 8;
	localparam int TXVC_OFF = 8;

	// Handshake codes and device states.
	typedef enum logic [1:0] {
		USD_HS_NONE = 2'b00,
		USD_HS_ACK = 2'b01,
		USD_HS_STALL = 2'b11
	} usd_hs_e;
	typedef enum logic [2:0] {
		USD_ST_ATTACHED = 3'b000,
		USD_ST_POWERED = 3'b001,
		USD_ST_DEFAULT = 3'b010,
		USD_ST_ADDRESS = 3'b011,
		USD_ST_CONFIGURED = 3'b100
	} usd_dstate_e;

	////////////////////////////////////////////////////////////////////////////////
	// Controller register offsets and command fields.
	localparam logic [7:0] CTL_CMD = 8'h00;
	localparam logic [7:0] CTL_WDATA = 8'h04;
	localparam logic [7:0] CTL_RDATA = 8'h08;
	localparam logic [7:0] CTL_STATUS = 8'h0C;
	localparam logic [7:0] CTL_CLOCKS = 8'h10;
	localparam logic [7:0] CTL_WAKE = 8'h14;
	localparam int CMD_WRITE = 8;
	localparam int CMD_PROTO = 14;
	typedef enum logic [2:0] {
		USD_OP_RAW = 3'b000,
		USD_OP_DEFAULT = 3'b001,
		USD_OP_SETADDR = 3'b010,
		USD_OP_CONFIG = 3'b011,
		USD_OP_STALL = 3'b100,
		USD_OP_SETUPCLR = 3'b101
	} usd_op_e;

	// Timing.
	localparam int CLK_PERIOD_NS = 5;
	localparam int SUSPEND_WAIT_US = 5000;
	localparam int K_HOLD_US = 2000;
	localparam int SUSPEND_WAIT_CYC = (SUSPEND_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int K_HOLD_CYC = (K_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 21;

endpackage

// ==== include/usd_if.sv ====
`timescale 1ns/100ps
interface usd_if;

	// Register access, link state, clock enables and pull-ups.
	logic reg_req;
	logic reg_write;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic reg_ack;
	logic irq;
	logic suspended;
	logic master_clock_en;
	logic port_clock_en;
	logic dp_pullup;
	logic dm_pullup;

	modport dev (
		input reg_req, reg_write, reg_addr, reg_wdata, master_clock_en, port_clock_en,
		input dp_pullup, dm_pullup,
		output reg_rdata, reg_ack, irq, suspended
	);
	modport ctl (
		output reg_req, reg_write, reg_addr, reg_wdata, master_clock_en, port_clock_en,
		output dp_pullup, dm_pullup,
		input reg_rdata, reg_ack, irq, suspended
	);

endinterface

// ==== src/usd_device.sv ====
`timescale 1ns/100ps
module usd_device import usd_pkg::*; (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Register side toward the controller.
	usd_if.dev bus,
	// Host transaction events.
	input wire logic token_valid_in,
	input wire logic [1:0] token_ep_in,
	input wire logic in_ack_in,
	// Bus state events.
	input wire logic bus_reset_end_in,
	input wire logic suspend_in,
	input wire logic resume_async_in,
	input wire logic sof_in,
	input wire logic sof_err_in,
	input wire logic [10:0] frame_in,
	// Handshake and state outputs.
	output logic hs_valid_out,
	output usd_hs_e hs_code_out,
	output usd_dstate_e dev_state_out,
	output logic xcvr_off_out
);

	typedef struct packed {
		logic [10:0] frm;
		logic frm_ok, frm_err, glb_addr, glb_conf;
		logic [6:0] fadd;
		logic function_enable_bit;
		logic [31:0] imr, sticky;
		logic [NUM_EP-1:0][31:0] csr;
		logic xcvr_off;
		logic [31:0] rdata;
		logic ack, irq, susp, hs_valid;
		usd_hs_e hs_code;
		usd_dstate_e dstate;
		logic rs1, rs2, rs3;
	} usd_dev_s;

	usd_dev_s s;
	usd_dev_s n;
	logic [NUM_EP-1:0] ep_old;
	logic [NUM_EP-1:0] ep_new;
	logic [7:0] a;

	////////////////////////////////////////////////////////////////////////////////
	// Endpoint interrupt pending while a stall-sent or IN-complete flag stands.
	for (genvar g = 0; g < NUM_EP; g++)
	begin : g_ep
		assign ep_old[g] = s.csr[g][CSR_SENT] | s.csr[g][CSR_IN_PACKET_ACKNOWLEDGED];
	end

	assign a = bus.reg_addr;

	// Next-state logic: register access first, hardware events after so a set wins.
	always_comb
	begin
		n = s;
		n.ack = 1'b0;
		n.hs_valid = 1'b0;
		n.rs1 = resume_async_in;
		n.rs2 = s.rs1;
		n.rs3 = s.rs2;
		if (bus.reg_req && !s.ack && bus.master_clock_en)
		begin
			n.ack = 1'b1;
			if (a == OFS_FRAME)
				n.rdata = {14'h0000, s.frm_ok, s.frm_err, 5'h00, s.frm};
			else if (a == OFS_GLOBAL)
				n.rdata = {30'h0000_0000, s.glb_conf, s.glb_addr};
			else if (a == OFS_FADDR)
				n.rdata = {23'h00_0000, s.function_enable_bit, 1'b0, s.fadd};
			else if (a == OFS_IMR)
				n.rdata = s.imr;
			else if (a == OFS_ISR)
				n.rdata = s.sticky | {28'h000_0000, ep_old};
			else if (a[7:4] == OFS_CSR[7:4])
				n.rdata = s.csr[a[3:2]];
			else if (a == OFS_TXVC)
				n.rdata = {23'h00_0000, s.xcvr_off, 8'h00};
			else
				n.rdata = 32'h0000_0000;
			if (bus.reg_write)
			begin
				if (a == OFS_GLOBAL)
				begin
					n.glb_addr = s.glb_addr | bus.reg_wdata[GLB_ADDR];
					n.glb_conf = bus.reg_wdata[GLB_CONF];
				end
				else if (a == OFS_FADDR)
				begin
					n.fadd = bus.reg_wdata[6:0];
					n.function_enable_bit = bus.reg_wdata[FADDR_FEN];
				end
				else if (a == OFS_IER)
					n.imr = s.imr | (bus.reg_wdata & IRQ_MASKABLE);
				else if (a == OFS_IDR)
					n.imr = s.imr & ~(bus.reg_wdata & IRQ_MASKABLE);
				else if (a == OFS_ICR)
					n.sticky = s.sticky & ~bus.reg_wdata;
				else if (a[7:4] == OFS_CSR[7:4])
				begin
					n.csr[a[3:2]][CSR_FORCE] = bus.reg_wdata[CSR_FORCE];
					n.csr[a[3:2]][CSR_EPEN] = bus.reg_wdata[CSR_EPEN];
					n.csr[a[3:2]][CSR_TYPE_LSB+:3] = bus.reg_wdata[CSR_TYPE_LSB+:3];
					n.csr[a[3:2]][CSR_SENT] = s.csr[a[3:2]][CSR_SENT] & bus.reg_wdata[CSR_SENT];
					n.csr[a[3:2]][CSR_IN_PACKET_ACKNOWLEDGED] = s.csr[a[3:2]][CSR_IN_PACKET_ACKNOWLEDGED]
						& bus.reg_wdata[CSR_IN_PACKET_ACKNOWLEDGED];
				end
				else if (a == OFS_TXVC)
					n.xcvr_off = bus.reg_wdata[TXVC_OFF];
			end
		end
		// Host tokens: forced halt first, then disabled endpoints stay silent.
		if (token_valid_in)
		begin
			n.hs_valid = 1'b1;
			if (s.csr[token_ep_in][CSR_FORCE])
			begin
				n.hs_code = USD_HS_STALL;
				n.csr[token_ep_in][CSR_SENT] = 1'b1;
			end
			else if (!n.csr[token_ep_in][CSR_EPEN] || (token_ep_in != 2'b00 && !s.function_enable_bit))
				n.hs_code = USD_HS_NONE;
			else
				n.hs_code = USD_HS_ACK;
		end
		if (in_ack_in)
			n.csr[token_ep_in][CSR_IN_PACKET_ACKNOWLEDGED] = 1'b1;
		if (sof_in)
		begin
			n.frm = frame_in;
			n.frm_ok = !sof_err_in;
			n.frm_err = sof_err_in;
			n.sticky[IRQ_SOF] = 1'b1;
		end
		if (suspend_in)
		begin
			n.sticky[IRQ_SUSPEND] = 1'b1;
			n.susp = 1'b1;
		end
		// Resume edge is taken from the second and third synchroniser stages.
		if (s.rs2 && !s.rs3 && s.susp)
		begin
			n.sticky[IRQ_WAKEUP] = 1'b1;
			n.susp = 1'b0;
		end
		if (bus_reset_end_in)
		begin
			n.imr = IMR_RESET;
			n.csr = '0;
			n.glb_addr = 1'b0;
			n.glb_conf = 1'b0;
			n.fadd = 7'h00;
			n.function_enable_bit = FADDR_RESET[FADDR_FEN];
			n.susp = 1'b0;
			n.sticky[IRQ_BUSRST] = 1'b1;
		end
		// Device state tracking.
		case (s.dstate)
			USD_ST_ATTACHED:
				if (bus.master_clock_en && bus.port_clock_en)
					n.dstate = USD_ST_POWERED;
			USD_ST_POWERED:
				if (bus_reset_end_in)
					n.dstate = USD_ST_DEFAULT;
			default:
				if (bus_reset_end_in)
					n.dstate = USD_ST_DEFAULT;
				else if (n.glb_conf)
					n.dstate = USD_ST_CONFIGURED;
				else if (n.glb_addr)
					n.dstate = USD_ST_ADDRESS;
				else
					n.dstate = USD_ST_DEFAULT;
		endcase
		if (!bus.dp_pullup)
			n.dstate = USD_ST_ATTACHED;
		for (int i = 0; i < NUM_EP; i++)
			ep_new[i] = n.csr[i][CSR_SENT] | n.csr[i][CSR_IN_PACKET_ACKNOWLEDGED];
		n.irq = (|((n.sticky | {28'h000_0000, ep_new}) & n.imr & IRQ_MASKABLE))
			| n.sticky[IRQ_BUSRST];
	end

	// State register.
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			s <= '0;
			s.imr <= IMR_RESET;
			s.function_enable_bit <= FADDR_RESET[FADDR_FEN];
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign bus.reg_rdata = s.rdata;
	assign bus.reg_ack = s.ack;
	assign bus.irq = s.irq;
	assign bus.suspended = s.susp;
	assign hs_valid_out = s.hs_valid;
	assign hs_code_out = s.hs_code;
	assign dev_state_out = s.dstate;
	assign xcvr_off_out = s.xcvr_off;

endmodule // usd_device

// ==== src/usd_controller.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Forced halt answers next token with stall.
// - Stall sets sent flag, interrupt pending meanwhile.
// - Protocol stall only on control endpoint.
// - Setup after stall clears sent flag.
// - Bus reset end sets unmaskable flag, interrupt.
// - Bus reset restores mask and endpoint registers.
// - Default state: endpoint 0, mask, transceiver on.
// - New address only after IN status acknowledged.
// - Address state: enable bit, address, function enable.
// - Configuration enables endpoints with their types.
// - Suspend sets flag, cleared by clear write.
// - Resume detected asynchronously, sets wakeup flag.
// - Register access only with master clock on.
// - Clocks off only during acknowledged suspend; the port clock here stops in any suspend.
// - Remote wakeup waits 5 ms after suspend.
// - K state starts within 10 ms.
// - K state held between 1 and 15 ms.
// - K state: drop DP pull-up, raise DM.
// - Endpoint registers at 0x030 and 0x050 strides.
// - Powered state needs both clocks enabled.
// - Function endpoints work only with function enable.
module usd_controller import usd_pkg::*; #(
	parameter int SUSPEND_WAIT_CYCLES = SUSPEND_WAIT_CYC,
	parameter int K_HOLD_CYCLES = K_HOLD_CYC
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_b_in,
	// AHB-Lite slave.
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	// Link toward the device.
	usd_if.ctl link
);

	typedef enum logic [1:0] {
		USD_SQ_IDLE = 2'b00,
		USD_SQ_ISSUE = 2'b01,
		USD_SQ_WAIT = 2'b10
	} usd_seq_e;

	typedef struct packed {
		logic last, wr;
		logic [7:0] addr;
		logic [31:0] data;
	} usd_step_s;

	typedef struct packed {
		logic a_valid, a_write;
		logic [7:0] a_addr;
		logic [31:0] cmd, wdata, rdata, hrdata;
		logic hready, resp;
		usd_seq_e seq;
		logic [2:0] step;
		logic refused, mclk, pclk, req, write;
		logic [7:0] addr;
		logic [31:0] data;
		logic wake_pend, k_active, dp, dm;
		logic [CNT_W-1:0] s_cnt, k_cnt;
	} usd_ctl_s;

	usd_ctl_s s;
	usd_ctl_s n;
	usd_step_s cur;
	usd_op_e op;
	logic legal;
	logic [7:0] ra;

	////////////////////////////////////////////////////////////////////////////////
	// Device access for one step of the command held in cmd.
	function automatic usd_step_s step_fn(input logic [31:0] cmd, input logic [31:0] wdata,
		input logic [31:0] rdata, input logic [2:0] step);
		usd_step_s r;
		r.last = 1'b1;
		r.wr = 1'b1;
		r.addr = OFS_CSR + {4'h0, cmd[13:12], 2'b00};
		r.data = rdata;
		case (usd_op_e'(cmd[11:9]))
			USD_OP_DEFAULT:
				case (step)
					3'd0:
					begin
						r.last = 1'b0;
						r.addr = OFS_CSR;
						r.data = 32'h0000_0001 << CSR_EPEN;
					end
					3'd1:
					begin
						r.last = 1'b0;
						r.addr = OFS_IER;
						r.data = IER_DEFAULT;
					end
					default:
					begin
						r.addr = OFS_TXVC;
						r.data = 32'h0000_0000;
					end
				endcase
			USD_OP_SETADDR:
				case (step)
					3'd0:
					begin
						r.last = 1'b0;
						r.wr = 1'b0;
						r.addr = OFS_CSR;
					end
					3'd1:
					begin
						r.last = 1'b0;
						r.addr = OFS_CSR;
						r.data = rdata & ~(32'h0000_0001 << CSR_IN_PACKET_ACKNOWLEDGED);
					end
					3'd2:
					begin
						r.last = 1'b0;
						r.addr = OFS_GLOBAL;
						r.data = 32'h0000_0001 << GLB_ADDR;
					end
					default:
					begin
						r.addr = OFS_FADDR;
						r.data = FADDR_RESET | {25'h000_0000, wdata[6:0]};
					end
				endcase
			USD_OP_CONFIG:
				if (step == 3'd0)
				begin
					r.last = 1'b0;
					r.data = (32'h0000_0001 << CSR_EPEN)
						| ({29'h0000_0000, wdata[2:0]} << CSR_TYPE_LSB);
				end
				else
				begin
					r.addr = OFS_GLOBAL;
					r.data = 32'h0000_0003;
				end
			USD_OP_STALL:
				if (step == 3'd0)
				begin
					r.last = 1'b0;
					r.wr = 1'b0;
				end
				else
					r.data = rdata | (32'h0000_0001 << CSR_FORCE);
			USD_OP_SETUPCLR:
				if (step == 3'd0)
				begin
					r.last = 1'b0;
					r.wr = 1'b0;
				end
				else
					r.data = rdata & ~(32'h0000_0001 << CSR_SENT);
			default:
			begin
				r.wr = cmd[CMD_WRITE];
				r.addr = cmd[7:0];
				r.data = wdata;
			end
		endcase
		return r;
	endfunction

	assign cur = step_fn(s.cmd, s.wdata, s.rdata, s.step);
	assign op = usd_op_e'(hwdata_in[11:9]);
	assign ra = haddr_in[7:0];

	// A command is refused when its operation is unknown or a protocol stall
	// names anything but the control endpoint.
	assign legal = (hwdata_in[11:9] <= USD_OP_SETUPCLR)
		&& !(op == USD_OP_STALL && hwdata_in[CMD_PROTO] && hwdata_in[13:12] != 2'b00);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb
	begin
		n = s;
		n.hready = 1'b1;
		n.resp = 1'b0;
		n.a_valid = hsel_in && htrans_in[1] && hready_in;
		n.a_write = hwrite_in;
		n.a_addr = ra;
		// Data phase of a write.
		if (s.a_valid && s.a_write)
		begin
			if (s.a_addr == CTL_CMD)
			begin
				if (s.seq == USD_SQ_IDLE && s.mclk && legal)
				begin
					n.cmd = hwdata_in;
					n.seq = USD_SQ_ISSUE;
					n.step = 3'd0;
					n.refused = 1'b0;
				end
				else
					n.refused = 1'b1;
			end
			else if (s.a_addr == CTL_WDATA)
				n.wdata = hwdata_in;
			else if (s.a_addr == CTL_CLOCKS)
			begin
				n.mclk = 1'b1;
				n.pclk = 1'b1;
				if (link.suspended && s.seq == USD_SQ_IDLE)
				begin
					n.pclk = hwdata_in[1];
					if (!link.irq)
						n.mclk = hwdata_in[0];
				end
				if ((n.mclk != hwdata_in[0]) || (n.pclk != hwdata_in[1]))
					n.refused = 1'b1;
			end
			else if (s.a_addr == CTL_WAKE && hwdata_in[0] && link.suspended)
				n.wake_pend = 1'b1;
		end
		// Device access sequencer.
		case (s.seq)
			USD_SQ_ISSUE:
			begin
				n.req = 1'b1;
				n.write = cur.wr;
				n.addr = cur.addr;
				n.data = cur.data;
				n.seq = USD_SQ_WAIT;
			end
			USD_SQ_WAIT:
				if (link.reg_ack)
				begin
					n.req = 1'b0;
					n.rdata = link.reg_rdata;
					n.seq = USD_SQ_ISSUE;
					if (usd_op_e'(s.cmd[11:9]) == USD_OP_SETADDR && s.step == 3'd0
						&& !link.reg_rdata[CSR_IN_PACKET_ACKNOWLEDGED])
						n.step = 3'd0;
					else if (cur.last)
						n.seq = USD_SQ_IDLE;
					else
						n.step = s.step + 3'd1;
				end
			// Idle keeps a command just taken; an unused code falls back to idle.
			default:
				if (s.seq != USD_SQ_IDLE)
					n.seq = USD_SQ_IDLE;
		endcase
		// Suspend age and remote wakeup K state.
		if (!link.suspended)
		begin
			n.s_cnt = '0;
			if (!s.k_active)
				n.wake_pend = 1'b0;
		end
		else if (s.s_cnt < CNT_W'(SUSPEND_WAIT_CYCLES))
			n.s_cnt = s.s_cnt + 1'b1;
		if (s.k_active)
		begin
			if (s.k_cnt == CNT_W'(K_HOLD_CYCLES - 1))
			begin
				n.k_active = 1'b0;
				n.dp = 1'b1;
				n.dm = 1'b0;
			end
			else
				n.k_cnt = s.k_cnt + 1'b1;
		end
		else if (s.wake_pend && s.s_cnt >= CNT_W'(SUSPEND_WAIT_CYCLES))
		begin
			n.k_active = 1'b1;
			n.wake_pend = 1'b0;
			n.k_cnt = '0;
			n.dp = 1'b0;
			n.dm = 1'b1;
		end
		// Read data for the address phase now being taken.
		if (ra == CTL_CMD)
			n.hrdata = n.cmd;
		else if (ra == CTL_WDATA)
			n.hrdata = n.wdata;
		else if (ra == CTL_RDATA)
			n.hrdata = n.rdata;
		else if (ra == CTL_STATUS)
			n.hrdata = {26'h000_0000, link.suspended, n.k_active, n.wake_pend, link.irq,
				n.refused, n.seq != USD_SQ_IDLE};
		else if (ra == CTL_CLOCKS)
			n.hrdata = {30'h0000_0000, n.pclk, n.mclk};
		else
			n.hrdata = 32'h0000_0000;
	end

	// State register; both clocks and the DP pull-up come up on.
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			s <= '0;
			s.hready <= 1'b1;
			s.mclk <= 1'b1;
			s.pclk <= 1'b1;
			s.dp <= 1'b1;
		end
		else
			s <= n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign hreadyout_out = s.hready;
	assign hrdata_out = s.hrdata;
	assign hresp_out = s.resp;
	assign link.reg_req = s.req;
	assign link.reg_write = s.write;
	assign link.reg_addr = s.addr;
	assign link.reg_wdata = s.data;
	assign link.master_clock_en = s.mclk;
	assign link.port_clock_en = s.pclk;
	assign link.dp_pullup = s.dp;
	assign link.dm_pullup = s.dm;

endmodule // usd_controller

// ==== sim/usd_chk.sv ====
`timescale 1ns/100ps
module usd_chk #(
	parameter int SUSPEND_WAIT_CYCLES = 20,
	parameter int K_HOLD_CYCLES = 10
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic rst_b_in,
	// Watched link signals.
	input wire logic reg_req,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic suspended,
	input wire logic master_clock_en,
	input wire logic port_clock_en,
	input wire logic dp_pullup,
	input wire logic dm_pullup
);
	int k_cnt;
	int s_cnt;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	////////////////////////////////////////////////////////////////////////////////
	// Counts cycles of K state and of suspend, the suspend count saturating so the wait cannot wrap.
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			k_cnt <= 0;
			s_cnt <= 0;
		end
		else
		begin
			k_cnt <= dm_pullup ? k_cnt + 1 : 0;
			s_cnt <= suspended ? s_cnt + ((s_cnt < 1000000) ? 1 : 0) : 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link handshake and the wakeup and clock gating sequence.
	ack_single_a: assert property (reg_ack |=> !reg_ack)
		else $error("link acknowledge lasted more than one cycle");
	ack_timely_a: assert property (reg_req && master_clock_en && !reg_ack |=> reg_ack)
		else $error("link request not acknowledged one cycle later");
	ack_cause_a: assert property (reg_ack |-> $past(reg_req) && $past(master_clock_en))
		else $error("link acknowledge without a request");
	req_hold_a: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr)
		&& $stable(reg_write) && $stable(reg_wdata))
		else $error("link request changed before acknowledge");
	req_clock_a: assert property (reg_req |-> master_clock_en)
		else $error("register access with master clock off");
	mck_off_a: assert property ($fell(master_clock_en) |-> $past(suspended))
		else $error("master clock stopped outside suspend");
	pck_off_a: assert property ($fell(port_clock_en) |-> $past(suspended))
		else $error("port clock stopped outside suspend");
	k_shape_a: assert property (dm_pullup |-> !dp_pullup)
		else $error("both data pull-ups on together");
	k_len_a: assert property ($fell(dm_pullup) |-> k_cnt == K_HOLD_CYCLES)
		else $error("K state length wrong");
	k_bound_a: assert property (dm_pullup |-> k_cnt < K_HOLD_CYCLES)
		else $error("K state held too long");
	k_wait_a: assert property ($rose(dm_pullup) |-> suspended
		&& s_cnt >= SUSPEND_WAIT_CYCLES)
		else $error("K state started too early after suspend");

	// Main scenarios reached.
	cover property (reg_ack && reg_write);
	cover property ($rose(dm_pullup));
	cover property ($fell(master_clock_en));
endmodule // usd_chk

// ==== sim/usd_device_state_and_stall_control_tb.sv ====
`timescale 1ns/100ps
module usd_device_state_and_stall_control_tb import usd_pkg::*;;
	localparam int S_W = 20;
	localparam int K_H = 10;
	logic clock_in = 0;
	logic rst_b_in = 0;
	logic hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic hwrite = 0;
	logic [31:0] hwdata = 0;
	logic hready;
	logic [31:0] hrdata;
	logic hresp;
	logic [3:0] ev = 0;
	logic [1:0] tok_ep = 0;
	logic resume = 0;
	logic hs_valid;
	usd_hs_e hs_code;
	usd_dstate_e dstate;
	logic xcvr_off;
	logic [31:0] rd;
	int bad_count = 0;
	int n_tests = 0;
	int cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Both ends joined by the interface, with the checker beside it.
	usd_if usd_if_inst ();
	usd_device usd_device_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .bus(usd_if_inst),
		.token_valid_in(ev[0]), .token_ep_in(tok_ep), .in_ack_in(ev[1]),
		.bus_reset_end_in(ev[2]), .suspend_in(ev[3]), .resume_async_in(resume),
		.sof_in(1'b0), .sof_err_in(1'b0), .frame_in(11'h0), .hs_valid_out(hs_valid),
		.hs_code_out(hs_code), .dev_state_out(dstate), .xcvr_off_out(xcvr_off));
	usd_controller #(.SUSPEND_WAIT_CYCLES(S_W), .K_HOLD_CYCLES(K_H)) usd_controller_inst (
		.clock_in(clock_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
		.hresp_out(hresp), .link(usd_if_inst));
	usd_chk #(.SUSPEND_WAIT_CYCLES(S_W), .K_HOLD_CYCLES(K_H)) usd_chk_inst (
		.clock_in(clock_in), .rst_b_in(rst_b_in), .reg_req(usd_if_inst.reg_req),
		.reg_write(usd_if_inst.reg_write), .reg_addr(usd_if_inst.reg_addr),
		.reg_wdata(usd_if_inst.reg_wdata), .reg_ack(usd_if_inst.reg_ack),
		.suspended(usd_if_inst.suspended), .master_clock_en(usd_if_inst.master_clock_en),
		.port_clock_en(usd_if_inst.port_clock_en), .dp_pullup(usd_if_inst.dp_pullup),
		.dm_pullup(usd_if_inst.dm_pullup));

	// Clock at 200 MHz.
	always #2.5 clock_in = ~clock_in;

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs under a thousand cycles.
	always @(posedge clock_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			complete_run();
		end
	end

	// Compares one value and counts it.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// One AHB single transfer; ready and read data are taken just before the edge.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		logic r;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do
		begin
			@(negedge clock_in);
			r = hready;
			@(posedge clock_in);
		end while (r !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do
		begin
			@(negedge clock_in);
			r = hready;
			rd = hrdata;
			@(posedge clock_in);
		end while (r !== 1'b1);
	endtask

	task automatic st();
		ahb(0, CTL_STATUS, 0);
	endtask

	// Device access through the command register, polled until idle.
	task automatic dev(input logic wr, input logic [7:0] a, input logic [2:0] op,
		input logic [2:0] ep, input logic [31:0] wd);
		int i;
		ahb(1, CTL_WDATA, wd);
		ahb(1, CTL_CMD, {17'h0_0000, ep, op, wr, a});
		i = 0;
		do
		begin
			st();
			i++;
		end while (rd[0] !== 1'b0 && i < 100);
		chk("dev idle", 0, rd[0]);
		ahb(0, CTL_RDATA, 0);
	endtask

	task automatic dr(input logic [7:0] a);
		dev(0, a, USD_OP_RAW, 0, 0);
	endtask

	task automatic dw(input logic [7:0] a, input logic [31:0] d);
		dev(1, a, USD_OP_RAW, 0, d);
	endtask

	// One-cycle event pulse toward the device.
	task automatic pulse(input int b);
		ev[b] <= 1'b1;
		@(posedge clock_in);
		ev[b] <= 1'b0;
	endtask

	// Token on an endpoint; the handshake stands one cycle later.
	task automatic tok(input logic [1:0] ep, input logic [1:0] e);
		tok_ep <= ep;
		pulse(0);
		#1;
		chk("hs valid", 1, hs_valid);
		chk("hs code", e, hs_code);
		@(posedge clock_in);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		int k;
		int b;
		repeat (3) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		#1;
		chk("powered", USD_ST_POWERED, dstate);
		ahb(0, 8'h18, 0);
		chk("ctl unmapped", 0, rd);
		chk("hresp okay", 0, hresp);
		dr(OFS_FADDR);
		chk("faddr reset", FADDR_RESET, rd);
		dr(OFS_IMR);
		chk("imr reset", IMR_RESET, rd);
		dr(OFS_EPRST);
		chk("dev unmapped", 0, rd);
		dw(OFS_CSR, 32'h0000_8000);
		dw(OFS_IDR, 32'hFFFF_FFFF);
		pulse(2);
		st();
		chk("busreset irq", 1, rd[2]);
		dr(OFS_ISR);
		chk("busreset flag", 1, rd[IRQ_BUSRST]);
		dr(OFS_IMR);
		chk("imr restored", IMR_RESET, rd);
		dr(OFS_CSR);
		chk("csr restored", 0, rd);
		chk("default state", USD_ST_DEFAULT, dstate);
		dw(OFS_ICR, 32'h0000_1000);
		st();
		chk("irq cleared", 0, rd[2]);
		dw(OFS_TXVC, 32'h0000_0100);
		dev(1, 0, USD_OP_DEFAULT, 0, 0);
		dr(OFS_CSR);
		chk("ep0 enabled", 1, rd[CSR_EPEN]);
		chk("xcvr on", 0, xcvr_off);
		dw(OFS_IER, IER_DEFAULT);
		tok(0, USD_HS_ACK);
		dev(1, 0, USD_OP_STALL, 0, 0);
		tok(0, USD_HS_STALL);
		dr(OFS_CSR);
		chk("sent flag", 1, rd[CSR_SENT]);
		st();
		chk("sent irq", 1, rd[2]);
		dev(1, 0, USD_OP_STALL, 3'b101, 0);
		st();
		chk("proto refused", 1, rd[1]);
		dev(1, 0, USD_OP_SETUPCLR, 0, 0);
		dr(OFS_CSR);
		chk("sent cleared", 0, rd[CSR_SENT]);
		st();
		chk("sent irq gone", 0, rd[2]);
		tok(1, USD_HS_NONE);
		tok_ep <= 2'd0;
		pulse(1);
		dev(1, 0, USD_OP_SETADDR, 0, 32'h0000_0025);
		dr(OFS_CSR);
		chk("in_packet_acknowledged cleared", 0, rd[CSR_IN_PACKET_ACKNOWLEDGED]);
		dr(OFS_FADDR);
		chk("faddr", 32'h0000_0125, rd);
		dr(OFS_GLOBAL);
		chk("addr state", 1, rd[GLB_ADDR]);
		chk("address state", USD_ST_ADDRESS, dstate);
		dev(1, 0, USD_OP_CONFIG, 3'b001, 32'h0000_0002);
		dr(OFS_CSR + 8'h04);
		chk("ep1 csr", 32'h0000_8200, rd & 32'h0000_8700);
		chk("configured", USD_ST_CONFIGURED, dstate);
		dr(OFS_CSR + 8'h08);
		chk("ep2 csr", 0, rd);
		dr(OFS_FDR + 8'h04);
		chk("ep1 fifo", 0, rd);
		tok(1, USD_HS_ACK);
		dw(OFS_FADDR, 32'h0000_0025);
		tok(1, USD_HS_NONE);
		ahb(1, CTL_CLOCKS, 0);
		st();
		chk("mck kept", 1, usd_if_inst.master_clock_en);
		pulse(3);
		st();
		chk("suspend irq", 32'h0000_0024, rd & 32'h0000_0024);
		dw(OFS_ICR, 32'h0000_0100);
		dr(OFS_ISR);
		chk("suspend cleared", 0, rd[IRQ_SUSPEND]);
		repeat (S_W + 5) @(posedge clock_in);
		ahb(1, CTL_WAKE, 1);
		k = 0;
		b = 0;
		repeat (40)
		begin
			@(negedge clock_in);
			k += usd_if_inst.dm_pullup;
			b += usd_if_inst.dm_pullup & usd_if_inst.dp_pullup;
		end
		@(posedge clock_in);
		chk("k length", K_H, k);
		chk("k shape", 0, b);
		chk("dp restored", 1, usd_if_inst.dp_pullup);
		ahb(1, CTL_CLOCKS, 0);
		st();
		chk("clocks off", 0, {usd_if_inst.master_clock_en, usd_if_inst.port_clock_en});
		resume <= 1'b1;
		repeat (4) @(posedge clock_in);
		ahb(1, CTL_CLOCKS, 3);
		dr(OFS_ISR);
		chk("wakeup flag", 1, rd[IRQ_WAKEUP]);
		st();
		chk("wakeup irq", 1, rd[2]);
		complete_run();
	end
endmodule // usd_device_state_and_stall_control_tb
